/* File: srb_reset_boot.sv */
`timescale 1ns/1ps
`include "srb_params.svh"

// Notes on behaviour
// - Any write to offset zero outside the off state triggers reset
// - Soft reset returns control registers to defaults
// - Soft reset with regulator enable high keeps sequencer and firmware memories
// - Wake-up resets like soft reset, keeps always-on
// - Sleep keeps sequencer memory, clears processor memory
// - Regulator enable low at soft reset: regulator off
// - Boot after reset; flag low, then high
// - Boot flag is an interrupt event source
// - Interrupt pin falls when boot completes
// - Offset zero reads device identification
// - Offset one reads revision in low byte
// - Mic pin pairs start in analog role
// - Pads take documented input/output reset states
// - Boot flag at bit 8 of raw status
module srb_reset_boot (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire srb_pkg::srb_req_t req,
  output srb_pkg::srb_rsp_t     rsp,
  input  wire logic             regulator_enable_pin,
  input  wire logic             sleep_req,
  input  wire logic             wake_evt,
  input  wire srb_pkg::srb_pad_t pad_cfg,
  output srb_pkg::srb_pad_t     pad_out,
  output logic                  boot_complete_flag,
  output logic                  boot_done_event,
  output logic                  irq_n,
  output logic                  ctrl_regs_rst,
  output logic                  aon_regs_rst,
  output logic                  seq_mem_clear,
  output logic                  dsp_mem_clear,
  output logic                  core_regulator_en
);

  // State and output registers
  srb_pkg::srb_state_t state_r;      // Core power/boot state
  srb_pkg::srb_state_t state_nxt;    // Next state
  logic                sw_rst_pend_r; // Soft reset waiting for write to finish
  logic                ack_r;        // Answer pulse
  logic [15:0]         rdata_r;      // Answer data
  logic [15:0]         rdata_nxt;    // Read mux result
  logic                flag_r;       // Boot complete flag
  logic                flag_nxt;     // Next flag
  logic                evt_r;        // Boot done event pulse
  logic                ctrl_rst_r;   // Control register reset
  logic                aon_rst_r;    // Always-on reset, power-on only
  logic                seq_clr_r;    // Sequencer memory clear
  logic                dsp_clr_r;    // Firmware memory clear
  logic                reg_on_r;     // Core regulator enable
  srb_pkg::srb_pad_t   pad_r;        // Registered pad control

  // Request decode
  wire take      = req.valid;
  wire take_wr   = take & req.write;
  wire take_rd   = take & ~req.write;
  wire hit_id    = (req.addr == `SRB_OFF_RESET_ID);
  wire hit_rev   = (req.addr == `SRB_OFF_REVISION);
  wire hit_sts   = (req.addr == `SRB_OFF_RAW_STS5);
  wire wr_rst    = take_wr & hit_id;

  // Soft reset paths once the write has completed
  wire is_off    = (state_r == srb_pkg::SRB_ST_OFF);
  wire rst_keep  = sw_rst_pend_r & ~is_off & regulator_enable_pin;
  wire rst_kill  = sw_rst_pend_r & ~is_off & ~regulator_enable_pin;
  wire woke      = (state_r == srb_pkg::SRB_ST_SLEEP) & wake_evt;
  wire tmr_start = rst_keep | woke;
  wire tmr_done;

  // Read mux; unmapped offsets read zero
  wire [15:0] sts_word = 16'(flag_r) << `SRB_BOOT_STS_BIT;
  assign rdata_nxt = hit_id  ? `SRB_DEVICE_ID :
                     hit_rev ? {8'h00, `SRB_REV_VALUE} :
                     hit_sts ? sts_word : 16'h0000;

  // Boot timer
  srb_boot_tmr u_tmr (
    .clk   (clk),
    .nrst  (nrst),
    .start (tmr_start),
    .done  (tmr_done)
  );

  // Next state; soft reset beats sleep entry
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      srb_pkg::SRB_ST_BOOT:  begin
        if (tmr_done) state_nxt = srb_pkg::SRB_ST_READY;
      end
      srb_pkg::SRB_ST_READY: begin
        if (sleep_req) state_nxt = srb_pkg::SRB_ST_SLEEP;
      end
      srb_pkg::SRB_ST_SLEEP: begin
        if (wake_evt) state_nxt = srb_pkg::SRB_ST_BOOT;
      end
      // Only a full power-up leaves this state
      srb_pkg::SRB_ST_OFF:   state_nxt = srb_pkg::SRB_ST_OFF;
    endcase
    if (rst_keep) state_nxt = srb_pkg::SRB_ST_BOOT;
    if (rst_kill) state_nxt = srb_pkg::SRB_ST_OFF;
  end

  assign flag_nxt = (state_nxt == srb_pkg::SRB_ST_READY);

  // Control port; writes elsewhere are acknowledged and stored by other blocks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_r         <= 1'b0;
      rdata_r       <= 16'h0000;
      sw_rst_pend_r <= 1'b0;
    end else begin
      ack_r         <= take;
      rdata_r       <= take_rd ? rdata_nxt : 16'h0000;
      // Reset held back one cycle so the write answers cleanly
      sw_rst_pend_r <= wr_rst;
    end
  end

  // State and boot flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= srb_pkg::SRB_ST_BOOT;
      flag_r  <= 1'b0;
      evt_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      flag_r  <= flag_nxt;
      evt_r   <= flag_nxt & ~flag_r;
    end
  end

  // Reset and memory controls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_rst_r <= 1'b1;
      aon_rst_r  <= 1'b1;
      seq_clr_r  <= 1'b1;
      dsp_clr_r  <= 1'b1;
      reg_on_r   <= 1'b1;
    end else begin
      ctrl_rst_r <= (state_nxt != srb_pkg::SRB_ST_READY);
      aon_rst_r  <= 1'b0;
      seq_clr_r  <= (state_nxt == srb_pkg::SRB_ST_OFF);
      dsp_clr_r  <= (state_nxt == srb_pkg::SRB_ST_OFF) |
                    (state_nxt == srb_pkg::SRB_ST_SLEEP);
      reg_on_r   <= (state_nxt != srb_pkg::SRB_ST_OFF);
    end
  end

  // Pads hold their reset roles until boot completes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pad_r <= `SRB_PAD_RESET;
    else       pad_r <= flag_nxt ? pad_cfg : `SRB_PAD_RESET;
  end

  // Outputs
  assign rsp.ack            = ack_r;
  assign rsp.rdata          = rdata_r;
  assign boot_complete_flag = flag_r;
  assign boot_done_event    = evt_r;
  assign irq_n              = ~flag_r;
  assign ctrl_regs_rst      = ctrl_rst_r;
  assign aon_regs_rst       = aon_rst_r;
  assign seq_mem_clear      = seq_clr_r;
  assign dsp_mem_clear      = dsp_clr_r;
  assign core_regulator_en  = reg_on_r;
  assign pad_out            = pad_r;

  // Soft reset request with regulator held up
  sequence s_swrst_keep;
    wr_rst && !is_off && regulator_enable_pin;
  endsequence

  // Write answered, then boot begins
  sequence s_ack_then_boot;
    ack_r ##1 (state_r == srb_pkg::SRB_ST_BOOT) && !flag_r;
  endsequence

  AST_SWRST_AFTER_ACK: assert property (@(posedge clk) disable iff (!nrst)
    s_swrst_keep ##1 regulator_enable_pin |-> s_ack_then_boot)
    else $error("Soft reset did not follow write completion");

  AST_BOOT_FLAG_LOW: assert property (@(posedge clk) disable iff (!nrst)
    rst_keep |=> !flag_r [*8])
    else $error("Boot flag high during boot");

  AST_CTRL_RST_READY: assert property (@(posedge clk) disable iff (!nrst)
    flag_r |-> !ctrl_regs_rst)
    else $error("Control reset active after boot");

  AST_WAKE_AON_KEPT: assert property (@(posedge clk) disable iff (!nrst)
    woke |=> ctrl_regs_rst && !aon_regs_rst && !flag_r)
    else $error("Wake-up disturbed always-on registers");

  AST_SLEEP_MEMS: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == srb_pkg::SRB_ST_SLEEP) |-> dsp_mem_clear && !seq_mem_clear)
    else $error("Sleep memory handling wrong");

  AST_REG_OFF: assert property (@(posedge clk) disable iff (!nrst)
    rst_kill |=> !core_regulator_en && seq_mem_clear && dsp_mem_clear)
    else $error("Regulator not turned off");

  AST_MEM_KEPT: assert property (@(posedge clk) disable iff (!nrst)
    rst_keep |=> core_regulator_en && !seq_mem_clear && !dsp_mem_clear)
    else $error("Memories cleared on soft reset");

  AST_READ_ID: assert property (@(posedge clk) disable iff (!nrst)
    take_rd && hit_id |=> rsp.ack && rsp.rdata == `SRB_DEVICE_ID)
    else $error("Identification read wrong");

  AST_READ_REV: assert property (@(posedge clk) disable iff (!nrst)
    take_rd && hit_rev |=> rsp.rdata[15:8] == 8'h00 && rsp.rdata[7:0] == `SRB_REV_VALUE)
    else $error("Revision read wrong");

  AST_READ_STS: assert property (@(posedge clk) disable iff (!nrst)
    take_rd && hit_sts |=> rsp.rdata[`SRB_BOOT_STS_BIT] == $past(flag_r))
    else $error("Boot status bit wrong");

  AST_BOOT_EVENT: assert property (@(posedge clk) disable iff (!nrst)
    $rose(flag_r) |-> boot_done_event && !irq_n ##1 !boot_done_event)
    else $error("Boot event not raised");

  AST_PADS_RESET: assert property (@(posedge clk) disable iff (!nrst)
    !flag_r |-> pad_out == `SRB_PAD_RESET && !pad_out.mic_digital)
    else $error("Pads left reset state early");

endmodule // srb_reset_boot

/* File: srb_params.svh */
`ifndef SRB_PARAMS_SVH
`define SRB_PARAMS_SVH

// Clock rate of the control core
`define SRB_CLK_MHZ        25
// Register offsets on the control port
`define SRB_OFF_RESET_ID   16'h0000
`define SRB_OFF_REVISION   16'h0001
`define SRB_OFF_RAW_STS5   16'h0D23
// Boot status bit in raw status register 5
`define SRB_BOOT_STS_BIT   8
// Identification value, arbitrary neutral code
`define SRB_DEVICE_ID      16'hA5C3
// Silicon revision, plain default
`define SRB_REV_VALUE      8'h01
// Boot sequence length in ns and derived cycles (rounded up)
`define SRB_BOOT_TIME_NS   1000
`define SRB_BOOT_CYCLES    ((`SRB_BOOT_TIME_NS * `SRB_CLK_MHZ + 999) / 1000)
// Pad reset state: mic analog, gpio in + pull-down, ldo/trst pull-down, aif clk in, tx out
`define SRB_PAD_RESET      7'h3E

`endif

/* File: srb_pkg.sv */
package srb_pkg;

  // Control port request
  typedef struct packed {
    logic        valid;  // Request present this cycle
    logic        write;  // 1 write, 0 read
    logic [15:0] addr;   // Register offset
    logic [15:0] wdata;  // Write data
  } srb_req_t;

  // Control port answer
  typedef struct packed {
    logic        ack;    // One-cycle completion pulse
    logic [15:0] rdata;  // Read data, valid with ack
  } srb_rsp_t;

  // Pad control bundle; oe_n low means pad is driven
  typedef struct packed {
    logic mic_digital;    // 1 digital mic role, 0 analog input
    logic gpio_oe_n;      // General purpose pads
    logic gpio_pulldown;  // General purpose pull-down
    logic ldo_pulldown;   // Regulator enable pad pull-down
    logic trst_pulldown;  // Test reset pad pull-down
    logic aif_clk_oe_n;   // Audio port clocks
    logic aif_tx_oe_n;    // Audio port transmit data
  } srb_pad_t;

  // Core power and boot state
  typedef enum logic [1:0] {
    SRB_ST_BOOT  = 2'b00,
    SRB_ST_READY = 2'b01,
    SRB_ST_SLEEP = 2'b10,
    SRB_ST_OFF   = 2'b11
  } srb_state_t;

endpackage

/* File: srb_boot_tmr.sv */
`timescale 1ns/1ps
`include "srb_params.svh"

// Boot sequence timer; loads on start, counts down to zero
module srb_boot_tmr (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic start,
  output logic      done
);

  logic [7:0] cnt_r;   // Cycles left in boot
  logic [7:0] cnt_nxt; // Next count

  // Reload wins so a reset during boot restarts the full sequence
  assign cnt_nxt = start ? 8'(`SRB_BOOT_CYCLES) : ((cnt_r != 8'h00) ? cnt_r - 8'h01 : cnt_r);
  assign done    = (cnt_r == 8'h00) & ~start;

  // Power-on starts with a full boot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt_r <= 8'(`SRB_BOOT_CYCLES);
    else       cnt_r <= cnt_nxt;
  end

endmodule // srb_boot_tmr

/* File: srb_host_model.sv */
`timescale 1ns/1ps

// Host on the control port; one request in flight at a time
module srb_host_model (
  input  wire logic              clk,
  output srb_pkg::srb_req_t      req,
  input  wire srb_pkg::srb_rsp_t rsp,
  input  wire logic              boot_complete_flag,
  input  wire logic              irq_n
);
  // Quiet span after wake-up: 1.5 ms of 40 ns cycles
  localparam int WAKE_WAIT = 37500;
  // Fixed init writes, in issue order
  logic [15:0] init_addr [9] = '{16'h0019, 16'h0081, 16'h02D4, 16'h035E, 16'h0443,
                                 16'h04B0, 16'h051B, 16'h055B, 16'h059B};
  logic [15:0] init_data [9] = '{16'h0001, 16'hE022, 16'h0000, 16'h000C, 16'hDC1A,
                                 16'h0066, 16'h0001, 16'h0001, 16'h0001};

  initial req = '0;

  // Held across the taking edge; answer read just after it
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                      output logic ack, output logic [15:0] rd);
    @(posedge clk);
    #1;
    req = '{1'b1, wr, a, d};
    @(posedge clk);
    #1;
    ack = rsp.ack;
    rd = rsp.rdata;
    // Released address and data lines must not keep the last value
    req = '{1'b0, wr, ~a, ~d};
  endtask

  // Init writes only once boot is flagged and the pin has fallen
  task automatic init_seq(output int acks);
    logic        a;
    logic [15:0] r;
    acks = 0;
    wait (boot_complete_flag === 1'b1 && irq_n === 1'b0);
    for (int i = 0; i < 9; i++) begin
      xfer(1'b1, init_addr[i], init_data[i], a, r);
      acks += int'(a === 1'b1);
    end
  endtask

  // No writes until the post-wake span has run out
  task automatic wake_wait();
    repeat (WAKE_WAIT) @(posedge clk);
  endtask
endmodule // srb_host_model

/* File: test_soft_reset_boot_and_id.sv */
`timescale 1ns/1ps
`include "srb_params.svh"

`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t %s", $time, m); end end

module test_soft_reset_boot_and_id;
  logic              clk = 0, nrst = 0, reg_en = 1, sleep_req = 0, wake_evt = 0;
  srb_pkg::srb_req_t req;
  srb_pkg::srb_rsp_t rsp;
  srb_pkg::srb_pad_t pad_cfg = 7'h55, pad_out;
  logic              flag, evt, irq_n, ctrl_rst, aon_rst, seq_clr, dsp_clr, reg_on, ack;
  logic [15:0]       rd;
  int                miscompares = 0, n_checks = 0, acks;

  srb_reset_boot i_dut (.clk(clk), .nrst(nrst), .req(req), .rsp(rsp), .regulator_enable_pin(reg_en),
    .sleep_req(sleep_req), .wake_evt(wake_evt), .pad_cfg(pad_cfg), .pad_out(pad_out),
    .boot_complete_flag(flag), .boot_done_event(evt), .irq_n(irq_n), .ctrl_regs_rst(ctrl_rst),
    .aon_regs_rst(aon_rst), .seq_mem_clear(seq_clr), .dsp_mem_clear(dsp_clr), .core_regulator_en(reg_on));
  srb_host_model i_host (.clk(clk), .req(req), .rsp(rsp), .boot_complete_flag(flag), .irq_n(irq_n));

  // 25 MHz clock
  always #20 clk = ~clk;

  // Bounded wait for boot, then the flag's side effects
  task automatic wait_boot();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, `SRB_BOOT_CYCLES + 1, "boot length")
    `CHK(evt, 1'b1, "no boot event")
    `CHK(irq_n, 1'b0, "irq not low")
    @(posedge clk);
    #1;
    `CHK(ctrl_rst, 1'b0, "ctrl reset held")
    `CHK(pad_out, pad_cfg, "pads not released")
  endtask

  // Power-up reset and pad states
  task automatic t_reset();
    repeat (6) @(posedge clk);
    `CHK(pad_out, srb_pkg::srb_pad_t'(`SRB_PAD_RESET), "pad reset")
    `CHK({flag, irq_n, aon_rst, seq_clr, dsp_clr}, 5'h0F, "reset outputs")
    #1 nrst = 1;
    wait_boot();
    $display("test reset done");
  endtask

  // Identity, revision, status bit, unmapped place
  task automatic t_ids();
    logic [15:0] a [4] = '{16'h0000, 16'h0001, `SRB_OFF_RAW_STS5, 16'h0002};
    logic [15:0] e [4] = '{`SRB_DEVICE_ID, {8'h00, `SRB_REV_VALUE}, 16'h0100, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      i_host.xfer(1'b0, a[i], 16'h0000, ack, rd);
      `CHK({ack, rd}, {1'b1, e[i]}, "read value")
    end
    i_host.init_seq(acks);
    `CHK(acks, 9, "init acks")
    $display("test ids done");
  endtask

  // Soft reset with regulator held on
  task automatic t_soft();
    reg_en = 1;
    i_host.xfer(1'b1, 16'h0000, 16'hFFFF, ack, rd);
    `CHK({ack, flag}, 2'b11, "reset before ack")
    @(posedge clk);
    #1;
    `CHK({flag, ctrl_rst, irq_n, aon_rst}, 4'h6, "soft reset")
    `CHK({seq_clr, dsp_clr, reg_on}, 3'b001, "memories kept")
    wait_boot();
    i_host.init_seq(acks);
    `CHK(acks, 9, "init after soft reset")
    $display("test soft done");
  endtask

  // Sleep and wake-up
  task automatic t_sleep();
    @(posedge clk);
    #1 sleep_req = 1;
    @(posedge clk);
    #1 sleep_req = 0;
    `CHK({dsp_clr, seq_clr, flag, ctrl_rst}, 4'h9, "sleep state")
    @(posedge clk);
    #1 wake_evt = 1;
    @(posedge clk);
    #1 wake_evt = 0;
    wait_boot();
    `CHK(aon_rst, 1'b0, "always-on reset")
    i_host.wake_wait();
    i_host.init_seq(acks);
    `CHK(acks, 9, "init after wake")
    $display("test sleep done");
  endtask

  // Soft reset with regulator pin low, recovered by nrst
  task automatic t_reg_off();
    reg_en = 0;
    i_host.xfer(1'b1, 16'h0000, 16'h1234, ack, rd);
    `CHK(ack, 1'b1, "reset write ack")
    @(posedge clk);
    #1;
    `CHK({reg_on, seq_clr, dsp_clr}, 3'b011, "regulator off")
    `CHK({flag, irq_n}, 2'b01, "flag while off")
    reg_en = 1;
    nrst = 0;
    @(posedge clk);
    #1 nrst = 1;
    wait_boot();
    i_host.init_seq(acks);
    `CHK(acks, 9, "init after hard reset")
    $display("test reg_off done");
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_reset();
    t_ids();
    t_soft();
    t_sleep();
    t_reg_off();
    final_report();
  end

  // Watchdog over expected run length
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule // test_soft_reset_boot_and_id
